// >>> rtl/aad_pkg.sv
`default_nettype none
package aad_pkg;
	// Data space locations of the four internal pointer and scratch registers
	localparam logic [7:0] PTR0_ADDR  = 8'h80;
	localparam logic [7:0] PTR1_ADDR  = 8'h81;
	localparam logic [7:0] SCR0_ADDR  = 8'h82;
	localparam logic [7:0] SCR1_ADDR  = 8'h83;
	localparam logic [5:0] REG_WINDOW = PTR0_ADDR[7:2];
	// Stack space
	localparam logic [2:0] STACK_DEPTH = 3'h6;
	// Cycle counts per instruction
	localparam logic [2:0] CYC_STD = 3'h4;
	localparam logic [2:0] CYC_BR  = 3'h2;
	localparam logic [2:0] CYC_BTB = 3'h5;
	// Reset values
	localparam logic [11:0] PC_RST   = 12'h000;
	localparam logic [7:0]  BYTE_RST = 8'h00;
	// Opcode classes, bits 7:4
	localparam logic [3:0] CLS_JUMP = 4'h8;
	localparam logic [3:0] CLS_CALL = 4'h9;
	localparam logic [3:0] CLS_BTB  = 4'hA;
	localparam logic [3:0] CLS_BIT  = 4'hB;
	localparam logic [3:0] CLS_IND0 = 4'hC;
	localparam logic [3:0] CLS_IND1 = 4'hD;
	localparam logic [3:0] CLS_DIR  = 4'hE;
	localparam logic [3:0] CLS_SHRT = 4'hF;
	// Operation codes, bits 3:0
	localparam logic [3:0] OP_LDA  = 4'h0;
	localparam logic [3:0] OP_STA  = 4'h1;
	localparam logic [3:0] OP_ADD  = 4'h2;
	localparam logic [3:0] OP_AND  = 4'h3;
	localparam logic [3:0] OP_CP   = 4'h4;
	localparam logic [3:0] OP_SUB  = 4'h5;
	localparam logic [3:0] OP_INC  = 4'h6;
	localparam logic [3:0] OP_DEC  = 4'h7;
	localparam logic [3:0] OP_CLR  = 4'h8;
	localparam logic [3:0] OP_COM  = 4'h9;
	localparam logic [3:0] OP_RLC  = 4'hA;
	localparam logic [3:0] OP_SLA  = 4'hB;
	localparam logic [3:0] OP_RET  = 4'hC;
	localparam logic [3:0] OP_NOP  = 4'hD;
	localparam logic [3:0] OP_CLRA = 4'hE;
	localparam logic [3:0] OP_LDIM = 4'hF;
	localparam logic [3:0] OP_LDIA = 4'hE;
	localparam logic [3:0] OP_IMM0 = 4'hA;
	typedef enum logic [4:0] {
		ST_FETCH = 5'b00001,
		ST_B2    = 5'b00010,
		ST_B3    = 5'b00100,
		ST_EXEC  = 5'b01000,
		ST_WAIT  = 5'b10000
	} aad_state_e;
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} aad_dreq_s;
	typedef struct packed {
		logic       valid;
		logic [1:0] len;
		logic [2:0] cyc;
		logic       ind;
		logic       shrt;
		logic       imm;
	} aad_dec_s;
endpackage : aad_pkg
`default_nettype wire

// >>> rtl/aad_core.sv
// What this block does
// - Six 12-bit stack cells hold return addresses for calls.
// - Immediate operand is the program byte right after the opcode.
// - Direct mode: next byte is an 8-bit data address, two-byte instruction.
// - Short direct: opcode bits pick one of 80h..83h, one byte.
// - Far jump/call target is opcode low nibble joined with next byte.
// - Relative branch: condition, direction bit, 4-bit span; range -15..+16.
// - Untaken branch simply continues with the following instruction.
// - Bit direct: opcode gives bit, next byte the address; set or clear.
// - Bit test-and-branch: three bytes, displacement -127..+128.
// - Indirect: opcode bit 4 picks pointer 80h or 81h.
// - Inherent instructions decode from the opcode alone.
// - Moves take 4 cycles, update zero, keep carry.
// - Load constant: accumulator sets zero; data byte in three bytes, no flags.
// - Sum, conjunction, compare, difference use accumulator; update zero and carry.
// - Increment, decrement, zero-fill reach any data location; increment and decrement update zero flag only, zero-fill no flags.
// - Invert, rotate, shift act on accumulator; update zero and carry.
// - Decoder recognises the valid opcodes of all eight classes.
// - Bit test-and-branch copies the tested bit into carry.
`default_nettype none
module aad_core
	import aad_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	// Program memory
	output logic      [11:0] pmem_addr_out,
	input  wire logic [7:0]  pmem_data_in,
	// Data space
	output aad_dreq_s        dmem_req_out,
	input  wire logic [7:0]  dmem_rdata_in,
	// Core state
	output logic      [7:0]  acc_out,
	output logic             zero_out,
	output logic             carry_out,
	output logic             illegal_out
);

	function automatic aad_dec_s decode(input logic [7:0] op);
		aad_dec_s d;
		d = '{valid: 1'b1, len: 2'h1, cyc: CYC_STD, ind: 1'b0, shrt: 1'b0, imm: 1'b0};
		if (!op[7]) begin
			d.cyc = CYC_BR;
		end else begin
			case (op[7:4])
				CLS_JUMP, CLS_CALL, CLS_BIT: d.len = 2'h2;
				CLS_BTB: begin
					d.len = 2'h3;
					d.cyc = CYC_BTB;
				end
				CLS_IND0, CLS_IND1: begin
					if (op[3:0] <= OP_CLR) begin
						d.ind = 1'b1;
					end else if (op[4] || op[3:0] == OP_LDIM) begin
						d.valid = 1'b0;
						d.cyc = CYC_BR;
					end else if (op[3:0] == OP_RET || op[3:0] == OP_NOP) begin
						d.cyc = CYC_BR;
					end
				end
				CLS_DIR: begin
					d.len = 2'h2;
					if (op[3:0] == OP_COM) begin
						d.len = 2'h3;
					end else if (op[3:0] == OP_LDIM) begin
						d.valid = 1'b0;
						d.len = 2'h1;
						d.cyc = CYC_BR;
					end else if (op[3:0] >= OP_IMM0) begin
						d.imm = 1'b1;
					end
				end
				default: d.shrt = 1'b1;
			endcase
		end
		return d;
	endfunction : decode

	function automatic logic [3:0] alu_op(input logic [7:0] op);
		logic [3:0] a;
		a = op[3:0];
		if (op[7:4] == CLS_SHRT) begin
			case (op[3:2])
				2'h0:    a = OP_LDA;
				2'h1:    a = OP_STA;
				2'h2:    a = OP_INC;
				default: a = OP_DEC;
			endcase
		end else if (op[7:4] == CLS_DIR) begin
			if (op[3:0] == OP_COM) begin
				a = OP_LDIM;
			end else if (op[3:0] == OP_LDIA) begin
				a = OP_LDA;
			end else if (op[3:0] >= OP_IMM0) begin
				a = op[3:0] - 4'h8;
			end
		end
		return a;
	endfunction : alu_op

	aad_state_e  st_q, st_d;
	logic [7:0]  op_q, op_d;
	logic [7:0]  b2_q, b2_d;
	logic [7:0]  b3_q, b3_d;
	logic [11:0] pc_q, pc_d;
	logic [11:0] ipc_q, ipc_d;
	logic [2:0]  cyc_q, cyc_d;
	logic [7:0]  acc_q, acc_d;
	logic        z_q, z_d;
	logic        c_q, c_d;
	logic        ill_q, ill_d;
	logic [7:0]  regs_q [4];
	logic [7:0]  regs_d [4];
	logic [11:0] stk_q [6];
	logic [11:0] stk_d [6];
	logic [2:0]  sp_q, sp_d;
	aad_dreq_s   dreq_q, dreq_d;

	aad_dec_s    dc;
	aad_dec_s    dcf;
	logic [7:0]  memv;
	logic [7:0]  opnd;
	logic [7:0]  wv;
	logic        wr_en;
	logic [8:0]  sum9;
	logic [8:0]  dif9;
	logic        tk;
	logic        last;

	always_comb begin
		st_d   = st_q;
		op_d   = op_q;
		b2_d   = b2_q;
		b3_d   = b3_q;
		pc_d   = pc_q;
		ipc_d  = ipc_q;
		cyc_d  = cyc_q + 3'h1;
		acc_d  = acc_q;
		z_d    = z_q;
		c_d    = c_q;
		ill_d  = 1'b0;
		regs_d = regs_q;
		stk_d  = stk_q;
		sp_d   = sp_q;
		dreq_d = '{we: 1'b0, addr: dreq_q.addr, wdata: dreq_q.wdata};
		dc     = decode(op_q);
		dcf    = decode(pmem_data_in);
		memv   = (dreq_q.addr[7:2] == REG_WINDOW) ? regs_q[dreq_q.addr[1:0]] : dmem_rdata_in;
		opnd   = dc.imm ? b2_q : memv;
		wv     = memv;
		wr_en  = 1'b0;
		sum9   = {1'b0, acc_q} + {1'b0, opnd};
		dif9   = {1'b0, acc_q} - {1'b0, opnd};
		tk     = 1'b0;
		last   = (cyc_q == dc.cyc - 3'h1);
		case (st_q)
			ST_FETCH: begin
				op_d  = pmem_data_in;
				ipc_d = pc_q;
				pc_d  = pc_q + 12'h001;
				cyc_d = 3'h1;
				ill_d = !dcf.valid;
				if (dcf.len != 2'h1) begin
					st_d = ST_B2;
				end else begin
					st_d = ST_EXEC;
					if (dcf.shrt) begin
						dreq_d.addr = {REG_WINDOW, pmem_data_in[1:0]};
					end else begin
						dreq_d.addr = pmem_data_in[4] ? regs_q[1] : regs_q[0];
					end
				end
			end
			ST_B2: begin
				b2_d = pmem_data_in;
				pc_d = pc_q + 12'h001;
				if (dc.len == 2'h3) begin
					st_d = ST_B3;
				end else begin
					st_d        = ST_EXEC;
					dreq_d.addr = pmem_data_in;
				end
			end
			ST_B3: begin
				b3_d        = pmem_data_in;
				pc_d        = pc_q + 12'h001;
				st_d        = ST_EXEC;
				dreq_d.addr = b2_q;
			end
			ST_EXEC: begin
				st_d = last ? ST_FETCH : ST_WAIT;
				if (!op_q[7]) begin
					case (op_q[6:5])
						2'h0:    tk = !z_q;
						2'h1:    tk = !c_q;
						2'h2:    tk = z_q;
						default: tk = c_q;
					endcase
					if (tk) begin
						pc_d = op_q[4] ? ipc_q - {8'h00, op_q[3:0]}
							: ipc_q + {8'h00, op_q[3:0]} + 12'h001;
					end
				end else begin
					case (op_q[7:4])
						CLS_JUMP: pc_d = {op_q[3:0], b2_q};
						CLS_CALL: begin
							pc_d = {op_q[3:0], b2_q};
							if (sp_q == STACK_DEPTH) begin
								stk_d[5] = pc_q;
							end else begin
								stk_d[sp_q] = pc_q;
								sp_d = sp_q + 3'h1;
							end
						end
						CLS_BTB: begin
							c_d = memv[op_q[3:1]];
							if (memv[op_q[3:1]] == op_q[0]) begin
								pc_d = ipc_q + 12'h001 + {{4{b3_q[7]}}, b3_q};
							end
						end
						CLS_BIT: begin
							wv[op_q[3:1]] = op_q[0];
							wr_en = 1'b1;
						end
						default: begin
							case (dc.valid ? alu_op(op_q) : OP_NOP)
								OP_LDA: begin
									acc_d = opnd;
									z_d   = (opnd == 8'h00);
								end
								OP_STA: begin
									wv    = acc_q;
									wr_en = 1'b1;
									z_d   = (acc_q == 8'h00);
								end
								OP_ADD: begin
									acc_d = sum9[7:0];
									c_d   = sum9[8];
									z_d   = (sum9[7:0] == 8'h00);
								end
								OP_AND: begin
									acc_d = acc_q & opnd;
									c_d   = 1'b0;
									z_d   = ((acc_q & opnd) == 8'h00);
								end
								OP_CP: begin
									c_d = dif9[8];
									z_d = (dif9[7:0] == 8'h00);
								end
								OP_SUB: begin
									acc_d = dif9[7:0];
									c_d   = dif9[8];
									z_d   = (dif9[7:0] == 8'h00);
								end
								OP_INC: begin
									wv    = memv + 8'h01;
									wr_en = 1'b1;
									z_d   = (wv == 8'h00);
								end
								OP_DEC: begin
									wv    = memv - 8'h01;
									wr_en = 1'b1;
									z_d   = (wv == 8'h00);
								end
								OP_CLR: begin
									wv    = 8'h00;
									wr_en = 1'b1;
								end
								OP_COM: begin
									acc_d = ~acc_q;
									c_d   = acc_q[7];
									z_d   = (acc_q == 8'hFF);
								end
								OP_RLC: begin
									{c_d, acc_d} = {acc_q, c_q};
									z_d = ({acc_q[6:0], c_q} == 8'h00);
								end
								OP_SLA: begin
									{c_d, acc_d} = {acc_q, 1'b0};
									z_d = (acc_q[6:0] == 7'h00);
								end
								OP_RET: begin
									if (sp_q != 3'h0) begin
										pc_d = stk_q[sp_q - 3'h1];
										sp_d = sp_q - 3'h1;
									end
								end
								OP_CLRA: begin
									acc_d = 8'h00;
									z_d   = 1'b1;
									c_d   = 1'b0;
								end
								OP_LDIM: begin
									wv    = b3_q;
									wr_en = 1'b1;
								end
								default: ;
							endcase
						end
					endcase
				end
				if (wr_en) begin
					if (dreq_q.addr[7:2] == REG_WINDOW) begin
						regs_d[dreq_q.addr[1:0]] = wv;
					end else begin
						dreq_d.we    = 1'b1;
						dreq_d.wdata = wv;
					end
				end
			end
			ST_WAIT: begin
				if (last) begin
					st_d = ST_FETCH;
				end
			end
			default: st_d = ST_FETCH;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q   <= ST_FETCH;
			op_q   <= BYTE_RST;
			b2_q   <= BYTE_RST;
			b3_q   <= BYTE_RST;
			pc_q   <= PC_RST;
			ipc_q  <= PC_RST;
			cyc_q  <= 3'h0;
			acc_q  <= BYTE_RST;
			z_q    <= 1'b0;
			c_q    <= 1'b0;
			ill_q  <= 1'b0;
			regs_q <= '{default: BYTE_RST};
			stk_q  <= '{default: PC_RST};
			sp_q   <= 3'h0;
			dreq_q <= '0;
		end else begin
			st_q   <= st_d;
			op_q   <= op_d;
			b2_q   <= b2_d;
			b3_q   <= b3_d;
			pc_q   <= pc_d;
			ipc_q  <= ipc_d;
			cyc_q  <= cyc_d;
			acc_q  <= acc_d;
			z_q    <= z_d;
			c_q    <= c_d;
			ill_q  <= ill_d;
			regs_q <= regs_d;
			stk_q  <= stk_d;
			sp_q   <= sp_d;
			dreq_q <= dreq_d;
		end
	end

	// Outputs straight from flops
	assign pmem_addr_out = pc_q;
	assign dmem_req_out  = dreq_q;
	assign acc_out       = acc_q;
	assign zero_out      = z_q;
	assign carry_out     = c_q;
	assign illegal_out   = ill_q;

endmodule : aad_core
`default_nettype wire

// >>> verif/aad_core_monitor.sv
`default_nettype none
module aad_core_monitor
	import aad_pkg::*;
(
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	// Observed ports
	input wire logic [11:0] pmem_addr_out,
	input wire logic [7:0]  pmem_data_in,
	input wire aad_dreq_s   dmem_req_out,
	input wire logic [7:0]  dmem_rdata_in,
	input wire logic [7:0]  acc_out,
	input wire logic        zero_out,
	input wire logic        carry_out,
	input wire logic        illegal_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb_core @(posedge clk_in);
	endclocking
	default disable iff (!rst_b_in);
	sequence s_no_write3;
		!dmem_req_out.we [*3];
	endsequence
	sequence s_acc_hold2;
		$stable(acc_out) [*2];
	endsequence
	chk_write_spacing: assert property (dmem_req_out.we |=> s_no_write3)
		else $error("writes too close");
	chk_write_keeps_carry: assert property (
		dmem_req_out.we |-> carry_out == $past(carry_out, 3))
		else $error("carry moved by write");
	chk_write_keeps_acc: assert property (
		dmem_req_out.we |-> acc_out == $past(acc_out, 3))
		else $error("acc moved by write");
	chk_window_held: assert property (
		dmem_req_out.we |-> dmem_req_out.addr[7:2] != REG_WINDOW)
		else $error("write pulse for internal register");
	chk_write_addr_holds: assert property (
		dmem_req_out.we |-> $stable(dmem_req_out.addr) ##1 $stable(dmem_req_out.wdata))
		else $error("write address or data moved");
	chk_acc_zero: assert property (
		$changed(acc_out) |-> zero_out == (acc_out == 8'h00))
		else $error("zero flag disagrees with acc");
	chk_acc_rate: assert property ($changed(acc_out) |=> s_acc_hold2)
		else $error("acc changed within three cycles");
	chk_illegal_noop: assert property (
		illegal_out |=> !illegal_out && $stable(acc_out) && !dmem_req_out.we)
		else $error("invalid opcode did more than nothing");
endmodule : aad_core_monitor
bind aad_core aad_core_monitor u_aad_core_monitor (
	.clk_in        (clk_in),
	.rst_b_in      (rst_b_in),
	.pmem_addr_out (pmem_addr_out),
	.pmem_data_in  (pmem_data_in),
	.dmem_req_out  (dmem_req_out),
	.dmem_rdata_in (dmem_rdata_in),
	.acc_out       (acc_out),
	.zero_out      (zero_out),
	.carry_out     (carry_out),
	.illegal_out   (illegal_out)
);
`default_nettype wire

// >>> verif/aad_mem_model.sv
`default_nettype none
module aad_mem_model
	import aad_pkg::*;
(
	// Clock
	input  wire logic        clk_in,
	// Program and data sides
	input  wire logic [11:0] prog_addr_in,
	output logic      [7:0]  prog_data_out,
	input  wire aad_dreq_s   dreq_in,
	output logic      [7:0]  drdata_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] prog [0:4095];
	logic [7:0] data [0:255];
	// Combinational reads
	assign prog_data_out = prog[prog_addr_in];
	assign drdata_out    = data[dreq_in.addr];
	// Write on the one-cycle strobe
	always @(posedge clk_in) begin
		if (dreq_in.we === 1'b1) begin
			data[dreq_in.addr] <= dreq_in.wdata;
		end
	end
endmodule : aad_mem_model
`default_nettype wire

// >>> verif/test_aad_core.sv
`default_nettype none
`define CMP(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		miscompares++; \
		$display("[FAIL] %s expected %h seen %h", nm, e, g); \
	end \
end
module test_aad_core
	import aad_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [11:0] pmem_addr_out;
	logic [7:0]  pmem_data_in;
	aad_dreq_s   dmem_req_out;
	logic [7:0]  dmem_rdata_in;
	logic [7:0]  acc_out;
	logic        zero_out;
	logic        carry_out;
	logic        illegal_out;
	int          miscompares = 0;
	int          compares = 0;
	int          illegals = 0;
	int          cyc = 0;
	int          last = 0;
	always #2 clk_in = ~clk_in;
	always @(posedge clk_in) cyc <= cyc + 1;
	always @(posedge clk_in) if (illegal_out === 1'b1) illegals <= illegals + 1;
	aad_core u_aad_core (
		.clk_in        (clk_in),
		.rst_b_in      (rst_b_in),
		.pmem_addr_out (pmem_addr_out),
		.pmem_data_in  (pmem_data_in),
		.dmem_req_out  (dmem_req_out),
		.dmem_rdata_in (dmem_rdata_in),
		.acc_out       (acc_out),
		.zero_out      (zero_out),
		.carry_out     (carry_out),
		.illegal_out   (illegal_out)
	);
	aad_mem_model u_aad_mem_model (
		.clk_in        (clk_in),
		.prog_addr_in  (pmem_addr_out),
		.prog_data_out (pmem_data_in),
		.dreq_in       (dmem_req_out),
		.drdata_out    (dmem_rdata_in)
	);
	task automatic tally_and_finish();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish
	task automatic load(input logic [11:0] a, input logic [7:0] img []);
		foreach (img[i]) u_aad_mem_model.prog[a + 12'(i)] = img[i];
	endtask : load
	// Wait for the instruction at a to leave fetch, then check
	task automatic step(input logic [11:0] a, input logic [7:0] ea, input logic [1:0] ef,
		input int n);
		int k;
		k = 0;
		while (pmem_addr_out !== a && k < 40) begin
			@(negedge clk_in);
			k++;
		end
		while (pmem_addr_out === a && k < 40) begin
			@(negedge clk_in);
			k++;
		end
		`CMP("reached", 1'b1, k < 40)
		`CMP("acc", ea, acc_out)
		`CMP("flags", ef, {zero_out, carry_out})
		if (n > 0) `CMP("cycles", n, cyc - last)
		last = cyc;
		$display("step at %h done", a);
	endtask : step
	initial begin
		repeat (1000) @(posedge clk_in);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		for (int i = 0; i < 4096; i++) u_aad_mem_model.prog[i] = 8'hCD;
		for (int i = 0; i < 256; i++) u_aad_mem_model.data[i] = 8'h00;
		u_aad_mem_model.data[8'h43] = 8'h5A;
		load(12'h000, {8'hEE, 8'h41, 8'hF4, 8'hE9, 8'h41, 8'hFB, 8'hEE, 8'h05, 8'hC2,
			8'hE1, 8'h40, 8'hEE, 8'h80, 8'hCB, 8'hCA, 8'hE6, 8'h40, 8'hC9, 8'hEC,
			8'hFF, 8'h43, 8'h63, 8'hCF, 8'hCF, 8'hCF, 8'h8A, 8'h20});
		load(12'hA20, {8'hCF, 8'h9B, 8'h00, 8'hF0, 8'hF9, 8'hD1, 8'hED, 8'h40, 8'hD5,
			8'hEB, 8'h0F, 8'hFE, 8'hEE, 8'h77, 8'hCE, 8'hE7, 8'h42, 8'hB4, 8'h42,
			8'hE8, 8'h43, 8'hCD, 8'h8A, 8'h3A, 8'h8A, 8'h38, 8'h12});
		load(12'hB00, {8'hB5, 8'h40, 8'hA3, 8'h40, 8'h10, 8'hA5, 8'h40, 8'h10});
		load(12'hB16, {8'hCC});
		repeat (8) @(posedge clk_in);
		rst_b_in <= 1'b1;
		step(12'h002, 8'h41, 2'b00, 0);
		step(12'h003, 8'h41, 2'b00, 4);
		step(12'h006, 8'h41, 2'b00, 4);
		step(12'h008, 8'h05, 2'b00, 4);
		step(12'h009, 8'h00, 2'b11, 4);
		step(12'h00B, 8'h00, 2'b11, 4);
		step(12'h00D, 8'h80, 2'b01, 4);
		step(12'h00E, 8'h00, 2'b11, 4);
		step(12'h00F, 8'h01, 2'b00, 4);
		step(12'h011, 8'h01, 2'b00, 4);
		step(12'h012, 8'hFE, 2'b00, 4);
		step(12'h014, 8'hFE, 2'b01, 4);
		step(12'h015, 8'hFE, 2'b01, 2);
		step(12'h019, 8'hFE, 2'b01, 2);
		step(12'hA20, 8'hFE, 2'b01, 4);
		step(12'hA21, 8'hFE, 2'b01, 2);
		step(12'hB00, 8'hFE, 2'b01, 4);
		step(12'hB02, 8'hFE, 2'b01, 4);
		step(12'hB05, 8'hFE, 2'b00, 5);
		step(12'hB16, 8'hFE, 2'b01, 5);
		step(12'hA23, 8'hFE, 2'b01, 2);
		step(12'hA24, 8'h41, 2'b01, 4);
		step(12'hA25, 8'h41, 2'b01, 4);
		step(12'hA26, 8'h41, 2'b01, 4);
		step(12'hA28, 8'h01, 2'b00, 4);
		step(12'hA29, 8'hC0, 2'b01, 4);
		step(12'hA2B, 8'h00, 2'b10, 4);
		step(12'hA2C, 8'h00, 2'b00, 4);
		step(12'hA2E, 8'h77, 2'b00, 4);
		step(12'hA2F, 8'h00, 2'b10, 4);
		step(12'hA31, 8'h00, 2'b00, 4);
		step(12'hA33, 8'h00, 2'b00, 4);
		step(12'hA35, 8'h00, 2'b00, 4);
		step(12'hA36, 8'h00, 2'b00, 2);
		step(12'hA3A, 8'h00, 2'b00, 4);
		step(12'hA38, 8'h00, 2'b00, 2);
		`CMP("data40", 8'h05, u_aad_mem_model.data[8'h40])
		`CMP("data41", 8'hFB, u_aad_mem_model.data[8'h41])
		`CMP("data01", 8'h41, u_aad_mem_model.data[8'h01])
		`CMP("data42", 8'hFB, u_aad_mem_model.data[8'h42])
		`CMP("data43", 8'h00, u_aad_mem_model.data[8'h43])
		`CMP("illegal", 1, illegals)
		tally_and_finish();
	end
endmodule : test_aad_core
`default_nettype wire
